//--- design/winding_diameter_limit_target.v
/*
  Winding diameter post-processing: averaging lag, limit pair clamp,
  compensation speed lag with delayed start, target reached flag, and an
  AXI4-Lite register slave with interrupt. Assumes the diameter and speed
  inputs and the start/done pulses come from logic on clk; select and
  restore inputs are pins and are synchronised here.
*/
// Behaviour
// - Clamp diameter between selected min and max
// - Clamp applies after the averaging filter
// - Two select inputs choose one of four pairs
// - Same selects choose material thickness too
// - Min not below max fixes diameter there
// - New pair or setting re-clamps present diameter
// - Limits 1 to 6553 mm, defaults 2 and 1
// - Speed lag 0 to 100 s, zero bypasses
// - Speed lag starts after 0 to 100 s wait
// - Winding: reached when diameter at or above target
// - Unwinding: reached when diameter at or below target
// - Target setting 1 to 6553, default 1
// - Averaging lag 0.02 s doubling per step
`include "wdl_defines.vh"
`default_nettype none
module winding_diameter_limit_target #(
  parameter TICK_CYCLES = `TICK_NS / `CLK_NS
) (
  input wire clk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire limit_select_low,
  input wire limit_select_high,
  input wire initial_diameter_restore,
  input wire [15:0] calc_diameter,
  input wire signed [15:0] comp_speed,
  input wire initial_calc_done,
  input wire run_start,
  output reg [15:0] present_diameter,
  output reg signed [15:0] comp_speed_filtered,
  output reg [15:0] selected_thickness,
  output reg target_diameter_reached,
  output reg irq
);

  function in_range;
    input [15:0] v;
    input [15:0] hi;
    begin
      in_range = (v >= `DIAM_LO) && (v <= hi);
    end
  endfunction

  function [15:0] byte_merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      byte_merge[7:0] = strb[0] ? data[7:0] : old[7:0];
      byte_merge[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  reg [2:0] sel_low_sync;
  reg [2:0] sel_high_sync;
  reg [2:0] restore_sync;
  wire sel_low = sel_low_sync[1];
  wire sel_high = sel_high_sync[1];

  reg [15:0] limit [0:7];
  reg [15:0] thick [0:3];
  reg [15:0] wait_s;
  reg [15:0] tc_s;
  reg [15:0] target;
  reg [15:0] stored_setting;
  reg wind_mode;
  reg [3:0] avg_count;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;

  reg [7:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg have_aw;
  reg have_w;
  reg stored_load;

  reg [31:0] tick_cnt;
  reg tick;
  reg signed [32:0] avg_acc;
  reg signed [32:0] speed_acc;
  reg [23:0] wait_cnt;
  reg waiting;
  reg filter_on;
  reg [1:0] pair_prev;
  reg clamp_prev;

  // Pin inputs pass two flip-flops; bit 2 is the edge history
  always @(posedge clk) begin
    if (rst) begin
      sel_low_sync <= 3'h0;
      sel_high_sync <= 3'h0;
      restore_sync <= 3'h7;
    end else begin
      sel_low_sync <= {sel_low_sync[1:0], limit_select_low};
      sel_high_sync <= {sel_high_sync[1:0], limit_select_high};
      restore_sync <= {restore_sync[1:0], initial_diameter_restore};
    end
  end
  wire restore_fall = restore_sync[2] & ~restore_sync[1];

  // pair index from the two selects
  wire [1:0] pair = {sel_high, sel_low};
  wire [15:0] sel_max = limit[{pair, 1'b0}];
  wire [15:0] sel_min = limit[{pair, 1'b1}];

  // averaging lag, time constant 10 ms * 2^n
  wire [15:0] avg_value = avg_acc[31:16];
  wire signed [32:0] avg_in = {1'b0, calc_diameter, 16'h0000};
  wire signed [32:0] avg_diff = avg_in - avg_acc;

  // min at or above max pins the diameter at max
  wire fixed = sel_min >= sel_max;
  wire [15:0] clamped = fixed ? sel_max :
    (avg_value > sel_max) ? sel_max :
    (avg_value < sel_min) ? sel_min : avg_value;
  wire clamp_hit = clamped != avg_value;

  // lag on compensation speed, step Ts/tau with Ts 10 ms
  wire signed [32:0] speed_in = {comp_speed[15], comp_speed, 16'h0000};
  wire signed [32:0] speed_diff = speed_in - speed_acc;
  wire [23:0] tau_ticks = {8'h00, tc_s} * {8'h00, `TICKS_PER_SEC};
  wire signed [32:0] speed_step = speed_diff / $signed({9'h000, tau_ticks});

  // Base tick and both filters
  always @(posedge clk) begin
    if (rst) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
      avg_acc <= {1'b0, `STORED_RESET, 16'h0000};
      speed_acc <= 33'h0;
      wait_cnt <= 24'h0;
      waiting <= 1'b0;
      filter_on <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_CYCLES - 1);
      if (tick_cnt == TICK_CYCLES - 1)
        tick_cnt <= 32'h0;
      else
        tick_cnt <= tick_cnt + 32'h1;
      if (stored_load) begin
        avg_acc <= {1'b0, stored_setting, 16'h0000};
      end else if (restore_fall) begin
        avg_acc <= {1'b0, stored_setting, 16'h0000};
      end else if (tick) begin
        if (avg_count == 4'h0)
          avg_acc <= avg_in;
        else
          avg_acc <= avg_acc + (avg_diff >>> avg_count);
      end
      // wait restarts at calc done or at start
      if (initial_calc_done || run_start) begin
        wait_cnt <= {8'h00, wait_s} * {8'h00, `TICKS_PER_SEC};
        waiting <= 1'b1;
        filter_on <= 1'b0;
      end else if (waiting && tick) begin
        if (wait_cnt == 24'h0) begin
          waiting <= 1'b0;
          filter_on <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt - 24'h1;
        end
      end
      if (tick) begin
        if (!filter_on || tc_s == 16'h0)
          speed_acc <= speed_in;
        else
          speed_acc <= speed_acc + speed_step;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      present_diameter <= `STORED_RESET;
      comp_speed_filtered <= 16'h0000;
      selected_thickness <= `THICK_RESET;
      target_diameter_reached <= 1'b0;
      pair_prev <= 2'h0;
      clamp_prev <= 1'b0;
    end else begin
      present_diameter <= clamped;
      comp_speed_filtered <= speed_acc[31:16];
      selected_thickness <= thick[pair];
      if (wind_mode)
        target_diameter_reached <= clamped >= target;
      else
        target_diameter_reached <= clamped <= target;
      pair_prev <= pair;
      clamp_prev <= clamp_hit;
    end
  end

  wire [2:0] events;
  assign events[`EV_TARGET] = (wind_mode ? clamped >= target : clamped <= target)
    & ~target_diameter_reached;
  assign events[`EV_CLAMP] = clamp_hit & ~clamp_prev;
  assign events[`EV_PAIR] = pair != pair_prev;

  wire do_write = have_aw && have_w && !s_axi_bvalid;
  wire [7:0] wa = wr_addr;
  wire wr_hit = (wa < `A_LIMIT_BASE + 8'h20) || (wa == `A_WAIT) ||
    (wa == `A_TC) || (wa == `A_TARGET) || (wa == `A_CTRL) ||
    (wa == `A_STORED) || (wa >= `A_THICK_BASE && wa < `A_DIAM) ||
    (wa == `A_IRQ_STAT) || (wa == `A_IRQ_MASK);
  wire [15:0] wr16 = wr_data[15:0];
  wire [2:0] limit_idx = wa[4:2];
  wire [1:0] thick_idx = wa[3:2] - 2'h1;

  // Write channel: address and data taken in either order
  integer i;
  always @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      have_aw <= 1'b0;
      have_w <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      stored_load <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
        limit[i] <= i[0] ? `MIN_RESET : `MAX_RESET;
      for (i = 0; i < 4; i = i + 1)
        thick[i] <= `THICK_RESET;
      wait_s <= `WAIT_RESET;
      tc_s <= `TC_RESET;
      target <= `TARGET_RESET;
      stored_setting <= `STORED_RESET;
      wind_mode <= 1'b1;
      avg_count <= `AVG_RESET;
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
      irq <= 1'b0;
    end else begin
      stored_load <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
        have_aw <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        have_w <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      irq_stat <= irq_stat | events;
      if (do_write) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        if (wa < `A_LIMIT_BASE + 8'h20) begin
          if (in_range(byte_merge(limit[limit_idx], wr_data, wr_strb), `DIAM_HI))
            limit[limit_idx] <= byte_merge(limit[limit_idx], wr_data, wr_strb);
        end else if (wa == `A_WAIT) begin
          if (wr16 <= `SEC_HI)
            wait_s <= wr16;
        end else if (wa == `A_TC) begin
          if (wr16 <= `SEC_HI)
            tc_s <= wr16;
        end else if (wa == `A_TARGET) begin
          if (in_range(wr16, `DIAM_HI))
            target <= wr16;
        end else if (wa == `A_CTRL) begin
          wind_mode <= wr_data[`CTRL_WIND_BIT];
          if (wr_data[`CTRL_AVG_MSB:`CTRL_AVG_LSB] <= `AVG_HI)
            avg_count <= wr_data[`CTRL_AVG_MSB:`CTRL_AVG_LSB];
        end else if (wa == `A_STORED) begin
          if (in_range(wr16, `DIAM_HI)) begin
            stored_setting <= wr16;
            stored_load <= 1'b1;
          end
        end else if (wa >= `A_THICK_BASE && wa < `A_DIAM) begin
          thick[thick_idx] <= byte_merge(thick[thick_idx], wr_data, wr_strb);
        end else if (wa == `A_IRQ_STAT) begin
          // New events win over the clear
          irq_stat <= (irq_stat & ~wr_data[2:0]) | events;
        end else if (wa == `A_IRQ_MASK) begin
          irq_mask <= wr_data[2:0];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // Read channel
  reg [31:0] rd_word;
  reg rd_hit;
  wire [7:0] ra = s_axi_araddr;
  always @* begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    if (ra < `A_LIMIT_BASE + 8'h20) begin
      rd_word = {16'h0, limit[ra[4:2]]};
    end else if (ra == `A_WAIT) begin
      rd_word = {16'h0, wait_s};
    end else if (ra == `A_TC) begin
      rd_word = {16'h0, tc_s};
    end else if (ra == `A_TARGET) begin
      rd_word = {16'h0, target};
    end else if (ra == `A_CTRL) begin
      rd_word = {24'h0, avg_count, 3'h0, wind_mode};
    end else if (ra == `A_STORED) begin
      rd_word = {16'h0, stored_setting};
    end else if (ra >= `A_THICK_BASE && ra < `A_DIAM) begin
      rd_word = {16'h0, thick[ra[3:2] - 2'h1]};
    end else if (ra == `A_DIAM) begin
      rd_word = {16'h0, present_diameter};
    end else if (ra == `A_SPEED) begin
      rd_word = {16'h0, comp_speed_filtered};
    end else if (ra == `A_IRQ_STAT) begin
      rd_word = {29'h0, irq_stat};
    end else if (ra == `A_IRQ_MASK) begin
      rd_word = {29'h0, irq_mask};
    end else if (ra == `A_STATUS) begin
      rd_word = {26'h0, filter_on, fixed, clamp_hit, target_diameter_reached, pair};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // winding_diameter_limit_target
`default_nettype wire

//--- inc/wdl_defines.vh
/*
  Offsets, reset values, field positions and timing counts for the winding
  diameter limit and target block. Assumes byte addressing on AXI4-Lite.
*/
`ifndef WDL_DEFINES_VH
`define WDL_DEFINES_VH
`define A_LIMIT_BASE 8'h00
`define A_WAIT 8'h20
`define A_TC 8'h24
`define A_TARGET 8'h28
`define A_CTRL 8'h2C
`define A_STORED 8'h30
`define A_THICK_BASE 8'h34
`define A_DIAM 8'h44
`define A_SPEED 8'h48
`define A_IRQ_STAT 8'h4C
`define A_IRQ_MASK 8'h50
`define A_STATUS 8'h54
`define MAX_RESET 16'h0002
`define MIN_RESET 16'h0001
`define WAIT_RESET 16'h0000
`define TC_RESET 16'h0000
`define TARGET_RESET 16'h0001
`define STORED_RESET 16'h0001
`define THICK_RESET 16'h0000
`define DIAM_LO 16'h0001
`define DIAM_HI 16'h1999
`define SEC_HI 16'h0064
`define AVG_HI 4'hA
`define AVG_RESET 4'h4
`define CTRL_WIND_BIT 0
`define CTRL_AVG_LSB 4
`define CTRL_AVG_MSB 7
`define EV_TARGET 0
`define EV_CLAMP 1
`define EV_PAIR 2
`define CLK_NS 20
`define TICK_NS 10000000
`define TICKS_PER_SEC 16'h0064
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- sim/pair_driver.sv
/* Controller model: drives the two pair select pins from a pair number.
   Assumes the bench changes the pair just after a clock edge. */
`default_nettype none
module pair_driver (
  input wire logic clk,
  input wire logic [1:0] pair,
  output logic limit_select_low = 1'h0,
  output logic limit_select_high = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk) begin
    {limit_select_high, limit_select_low} <= pair;
  end
endmodule // pair_driver
`default_nettype wire

//--- sim/wdl_checker.sv
/* Port checker for the diameter limit block.
   Assumes one clock and a synchronous active-high reset. */
`default_nettype none
module wdl_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] present_diameter,
  input wire logic target_diameter_reached,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff rst;
  chk_diam_span:
    assert property (present_diameter >= 16'h0001 && present_diameter <= 16'h1999)
    else $error("diameter outside limits");
  chk_reset_vals:
    assert property ($fell(rst) |-> present_diameter == 16'h0001 && !target_diameter_reached
      && !irq) else $error("bad value after reset");
  chk_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_b_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during data");
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (irq);
  cover property ($rose(target_diameter_reached));
endmodule // wdl_checker
bind winding_diameter_limit_target wdl_checker u_chk (.clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .present_diameter, .target_diameter_reached, .irq);
`default_nettype wire

//--- sim/winding_diameter_limit_target_tb_top.sv
/* Bench top: bus master tasks, clamp model, pair, interrupt and speed tests.
   Assumes the pair driver model and a shortened tick. */
`default_nettype none
module winding_diameter_limit_target_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4;
  logic clk = 1'h0, rst = 1'h1, run_start = 1'h0;
  logic initial_diameter_restore = 1'h1, initial_calc_done = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic [15:0] calc_diameter = 16'h0000;
  logic signed [15:0] comp_speed = 16'sh0000;
  logic [1:0] pair = 2'h0, resp;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire logic limit_select_low, limit_select_high, target_diameter_reached;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [15:0] present_diameter, selected_thickness;
  wire logic signed [15:0] comp_speed_filtered;
  int n_mismatch = 0, check_count = 0, p, d, e, tgt = 1, wind = 1;
  int mx[4] = '{2, 2, 2, 2}, mn[4] = '{1, 1, 1, 1}, th[4];
  always #10 clk = ~clk;
  winding_diameter_limit_target #(.TICK_CYCLES(TK)) dut (.clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .limit_select_low, .limit_select_high, .initial_diameter_restore, .calc_diameter,
    .comp_speed, .initial_calc_done, .run_start, .present_diameter,
    .comp_speed_filtered, .selected_thickness, .target_diameter_reached, .irq);
  pair_driver ctl (.clk, .pair, .limit_select_low, .limit_select_high);
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t mismatch got %h want %h", $time, got, exp);
    end
  endtask
  task automatic gone(input int k);
    if (k >= 80) begin
      n_mismatch++;
      $display("[ERR] %0t bus wait ran out", $time);
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && k < 80);
    s_axi_bready <= 1'h0;
    resp = s_axi_bresp;
    gone(k);
  endtask
  task automatic rdr(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && k < 80);
    s_axi_rready <= 1'h0;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    gone(k);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("[ERR] %0t run took too long", $time);
    results();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    void'($urandom(32'h4CB98D09));
    for (int i = 0; i < 8; i++) begin
      rdr(8'(i * 4));
      cmp(rd, i % 2 ? 1 : 2);
    end
    rdr(8'h20);
    cmp(rd, 0);
    rdr(8'h24);
    cmp(rd, 0);
    rdr(8'h28);
    cmp(rd, 1);
    rdr(8'h60);
    cmp(resp, 2'h2);
    $display("reset values done");
    for (int i = 0; i < 24; i++) begin
      p = $urandom % 4;
      mx[p] = 1 + $urandom % 6553;
      mn[p] = 1 + $urandom % (i % 4 ? mx[p] : 6553);
      th[p] = 1 + $urandom % 6553;
      tgt = 1 + $urandom % 6553;
      wind = i < 12;
      d = $urandom % 8000;
      wr(8'h2C, wind);
      wr(8'(p * 8), mx[p]);
      wr(8'(p * 8 + 4), mn[p]);
      wr(8'(52 + p * 4), th[p]);
      wr(8'h28, tgt);
      calc_diameter <= 16'(d);
      pair <= 2'(p);
      e = mn[p] >= mx[p] ? mx[p] : d > mx[p] ? mx[p] : d < mn[p] ? mn[p] : d;
      repeat (2 * TK + 8) @(posedge clk);
      cmp(present_diameter, e);
      cmp(selected_thickness, th[p]);
      cmp(target_diameter_reached, wind ? e >= tgt : e <= tgt);
    end
    $display("clamp and pair tests done");
    wr(8'h00, 0);
    wr(8'h00, 6554);
    rdr(8'h00);
    cmp(rd, mx[0]);
    wr(8'h28, 0);
    cmp(resp, 2'h0);
    rdr(8'h28);
    cmp(rd, tgt);
    wr(8'h24, 101);
    rdr(8'h24);
    cmp(rd, 0);
    wr(8'h60, 32'h1);
    cmp(resp, 2'h2);
    $display("range tests done");
    wr(8'h4C, 7);
    wr(8'h50, 4);
    pair <= pair + 2'h1;
    repeat (8) @(posedge clk);
    cmp(irq, 1);
    wr(8'h4C, 4);
    repeat (2) @(posedge clk);
    cmp(irq, 0);
    wr(8'h50, 0);
    pair <= pair + 2'h1;
    repeat (8) @(posedge clk);
    cmp(irq, 0);
    $display("interrupt tests done");
    wr(8'h2C, 32'hA1);
    calc_diameter <= 16'h03E8;
    wr(8'({pair, 3'h0}), 32'h1999);
    wr(8'({pair, 3'h4}), 32'h1);
    wr(8'h30, 32'h3E8);
    repeat (4) @(posedge clk);
    cmp(present_diameter, 16'h03E8);
    calc_diameter <= 16'h04B0;
    repeat (10 * TK) @(posedge clk);
    cmp(present_diameter >= 16'h03E9 && present_diameter <= 16'h03EB, 1);
    wr(8'h2C, 32'h1);
    repeat (TK + 2) @(posedge clk);
    cmp(present_diameter, 16'h04B0);
    wr(8'h2C, 32'hA1);
    initial_diameter_restore <= 1'h0;
    repeat (6) @(posedge clk);
    cmp(present_diameter, 16'h03E8);
    initial_diameter_restore <= 1'h1;
    $display("averaging and reload tests done");
    comp_speed <= 16'sh012C;
    repeat (TK + 2) @(posedge clk);
    cmp(comp_speed_filtered, 16'sh012C);
    wr(8'h20, 1);
    wr(8'h24, 1);
    run_start <= 1'h1;
    @(posedge clk);
    run_start <= 1'h0;
    comp_speed <= 16'shFF38;
    repeat (4 * TK) @(posedge clk);
    cmp(comp_speed_filtered, 16'shFF38);
    repeat (100 * TK) @(posedge clk);
    comp_speed <= 16'sh0320;
    repeat (2 * TK) @(posedge clk);
    cmp(comp_speed_filtered < 16'sh0000 && comp_speed_filtered >= 16'shFF38, 1);
    initial_calc_done <= 1'h1;
    @(posedge clk);
    initial_calc_done <= 1'h0;
    repeat (TK + 2) @(posedge clk);
    cmp(comp_speed_filtered, 16'sh0320);
    $display("speed filter done");
    results();
  end
endmodule // winding_diameter_limit_target_tb_top
`default_nettype wire
